// ---- core/ccp_block.sv ----
// Design decisions made here: the Avalon-MM interface to the registers and the address map.
`timescale 1ns/1ps
// What this block does
// - Special-event mode plus timer equal to compare value sets the channel interrupt flag.
// - Only channel five starts a conversion on a match, and only if converter enabled.
// - Matched timer is cleared to zero one cycle after its next tick, not at match.
// - Special-event mode drives nothing new on the channel output pins.
// - Match-caused timer clear never sets the timer overflow flag; only real overflow does.
// - Rewriting the compare value before the timer edge cancels the pending clear.
// - Compare value thus acts as a 16-bit period for the selected timer.
// - Compare needs the system clock; no matches are made while it is stopped.
// - Half-bridge mode drives PWM on the primary pin and its complement on the other.
// - Seven-bit dead-band count delays each output going active by that many cycles.
// - Dead-band longer than the active time keeps that output inactive all period.
// - Control register holds output config 7:6, duty low bits 5:4, mode 3:0.
// - Two-bit timer choice per channel, packed in two timer-select registers.
module ccp_block
	import ccp_pkg::*;
#(
	parameter int DB_W = 7
) (
	input  wire logic        sys_clk,
	input  wire logic        rstn,
	input  wire logic [7:0]  avs_address,
	input  wire logic        avs_read,
	input  wire logic        avs_write,
	input  wire logic [31:0] avs_writedata,
	input  wire logic [3:0]  avs_byteenable,
	output logic      [31:0] avs_readdata,
	output logic             avs_waitrequest,
	input  wire logic [2:0]  timer_tick,
	input  wire logic [47:0] timer_count_pair,
	input  wire logic [2:0]  timer_wrap,
	output logic      [2:0]  timer_clear,
	output logic      [2:0]  timer_overflow_flag,
	input  wire logic        adc_enabled,
	output logic             adc_start,
	output logic             pwm_out_primary,
	output logic             pwm_out_complement,
	output logic             irq
);

	// ----------------------------------------
	// State
	// ----------------------------------------
	typedef struct packed {
		logic [NUM_CHAN-1:0][7:0]  ctrl;
		logic [NUM_CHAN-1:0][15:0] cmp;
		logic [7:0]                tsel_a;
		logic [7:0]                tsel_b;
		logic [7:0]                db;
		logic [7:0]                period;
		logic [7:0]                duty;
		logic [NUM_CHAN-1:0]       irq_st;
		logic [NUM_CHAN-1:0]       irq_mask;
		logic [NUM_CHAN-1:0]       matched;
		logic [NUM_CHAN-1:0]       pend;
		logic [2:0]                ovf;
		logic [2:0]                clr;
		logic                      adc;
		logic [9:0]                pcnt;
		logic                      pwm_raw;
		logic [DB_W-1:0]           dcnt;
		logic                      out_a;
		logic                      out_b;
		logic                      ack;
		logic [31:0]               rdata;
	} state_t;

	state_t s_q;
	state_t s_d;

	logic [7:0]                wbyte;
	logic                      wr_hit;
	logic [NUM_CHAN-1:0][1:0]  chan_tmr;
	logic [NUM_CHAN-1:0][15:0] chan_val;
	logic [NUM_CHAN-1:0]       chan_hit;
	logic [NUM_CHAN-1:0]       chan_tick;
	logic [NUM_CHAN-1:0]       ctrl_sel;
	logic [NUM_CHAN-1:0]       vlo_sel;
	logic [NUM_CHAN-1:0]       vhi_sel;
	logic [NUM_TMR-1:0]        wrap_set;
	logic                      half;
	logic [9:0]                period_full;
	logic [9:0]                duty_full;
	logic                      period_end;
	logic                      duty_on;

	// ----------------------------------------
	// Bus qualification
	// ----------------------------------------
	// A write lands only at the edge where waitrequest is low, and only on byte lane 0.
	always_comb begin
		wbyte  = avs_writedata[7:0];
		wr_hit = avs_write && s_q.ack && avs_byteenable[0];
	end

	// ----------------------------------------
	// Channel timer selection
	// ----------------------------------------
	// Selection code three falls back to the last timer.
	always_comb begin
		chan_tmr[0] = s_q.tsel_a[1:0];
		chan_tmr[1] = s_q.tsel_a[3:2];
		chan_tmr[2] = s_q.tsel_a[5:4];
		chan_tmr[3] = s_q.tsel_b[1:0];
		chan_tmr[4] = s_q.tsel_b[3:2];
		for (int c = 0; c < NUM_CHAN; c++) begin
			if (chan_tmr[c] > 2'h2) begin
				chan_tmr[c] = 2'h2;
			end
		end
	end

	// ----------------------------------------
	// Compare detection
	// ----------------------------------------
	always_comb begin
		for (int c = 0; c < NUM_CHAN; c++) begin
			chan_val[c]  = timer_count_pair[16*chan_tmr[c] +: 16];
			chan_hit[c]  = (s_q.ctrl[c][3:0] == MODE_SPECIAL) && (chan_val[c] == s_q.cmp[c]);
			chan_tick[c] = timer_tick[chan_tmr[c]];
		end
		for (int t = 0; t < NUM_TMR; t++) begin
			wrap_set[t] = timer_wrap[t] && timer_tick[t];
		end
	end

	// ----------------------------------------
	// Address decode
	// ----------------------------------------
	always_comb begin
		for (int c = 0; c < NUM_CHAN; c++) begin
			ctrl_sel[c] = (avs_address == OFS_CTRL_BASE + 8'(4*c));
			vlo_sel[c]  = (avs_address == OFS_VALLO_BASE + 8'(4*c));
			vhi_sel[c]  = (avs_address == OFS_VALHI_BASE + 8'(4*c));
		end
	end

	// ----------------------------------------
	// Half-bridge waveform
	// ----------------------------------------
	// Only channel one offers half-bridge output; the period steps on timer two.
	always_comb begin
		half        = (s_q.ctrl[0][3:2] == MODE_PWM_TOP) && (s_q.ctrl[0][7:6] == OUT_CFG_HALF);
		period_full = {s_q.period, 2'h3};
		duty_full   = {s_q.duty, s_q.ctrl[0][5:4]};
		period_end  = (s_q.pcnt >= period_full);
		duty_on     = half && (s_q.pcnt < duty_full);
	end

	// ----------------------------------------
	// Next state
	// ----------------------------------------
	always_comb begin
		s_d       = s_q;
		s_d.ack   = (avs_read || avs_write) && !s_q.ack;
		s_d.adc   = 1'b0;
		s_d.clr   = 3'h0;

		// Timer overflow flags come only from real wraps.
		for (int t = 0; t < NUM_TMR; t++) begin
			if (wrap_set[t]) begin
				s_d.ovf[t] = 1'b1;
			end
		end

		// Special-event compare per channel.
		for (int c = 0; c < NUM_CHAN; c++) begin
			s_d.matched[c] = chan_hit[c];
			if (chan_hit[c] && !s_q.matched[c]) begin
				s_d.irq_st[c] = 1'b1;
				s_d.pend[c]   = 1'b1;
				if (c == ADC_CHAN && adc_enabled) begin
					s_d.adc = 1'b1;
				end
			end
			if (s_q.pend[c] && chan_tick[c]) begin
				s_d.clr[chan_tmr[c]] = 1'b1;
				s_d.pend[c]   = 1'b0;
			end
			if (s_q.ctrl[c][3:0] != MODE_SPECIAL) begin
				s_d.pend[c] = 1'b0;
			end
		end

		// Register writes; a compare rewrite drops the pending clear.
		if (wr_hit) begin
			for (int c = 0; c < NUM_CHAN; c++) begin
				if (ctrl_sel[c]) begin
					s_d.ctrl[c] = wbyte;
				end
				if (vlo_sel[c]) begin
					s_d.cmp[c][7:0] = wbyte;
					s_d.pend[c]     = 1'b0;
				end
				if (vhi_sel[c]) begin
					s_d.cmp[c][15:8] = wbyte;
					s_d.pend[c]      = 1'b0;
				end
			end
			case (avs_address)
				OFS_TSEL_A:     s_d.tsel_a = {2'h0, wbyte[5:0]};
				OFS_TSEL_B:     s_d.tsel_b = {4'h0, wbyte[3:0]};
				OFS_PWM_DB:     s_d.db     = {1'b0, wbyte[6:0]};
				OFS_PWM_PERIOD: s_d.period = wbyte;
				OFS_PWM_DUTY:   s_d.duty   = wbyte;
				OFS_IRQ_MASK:   s_d.irq_mask = wbyte[NUM_CHAN-1:0];
				default: begin
				end
			endcase
			if (avs_address == OFS_IRQ_STATUS) begin
				for (int c = 0; c < NUM_CHAN; c++) begin
					if (wbyte[c] && !(s_d.irq_st[c] && !s_q.irq_st[c])) begin
						s_d.irq_st[c] = 1'b0;
					end
				end
			end
			if (avs_address == OFS_PEND_STATUS) begin
				for (int t = 0; t < NUM_TMR; t++) begin
					if (wbyte[t] && !(timer_wrap[t] && timer_tick[t])) begin
						s_d.ovf[t] = 1'b0;
					end
				end
			end
		end

		// Half-bridge PWM on channel one, timer two tick as the period clock.
		if (timer_tick[1]) begin
			if (period_end) begin
				s_d.pcnt = 10'h000;
			end else begin
				s_d.pcnt = s_q.pcnt + 10'h001;
			end
		end
		s_d.pwm_raw = duty_on;
		if (s_d.pwm_raw != s_q.pwm_raw) begin
			s_d.dcnt = DB_W'(s_q.db[6:0]);
		end else if (s_q.dcnt != '0) begin
			s_d.dcnt = s_q.dcnt - 1'b1;
		end
		if (!half) begin
			s_d.out_a = 1'b0;
			s_d.out_b = 1'b0;
		end else if (s_d.pwm_raw != s_q.pwm_raw) begin
			s_d.out_a = 1'b0;
			s_d.out_b = 1'b0;
			if (s_q.db[6:0] == 7'h00) begin
				s_d.out_a = s_d.pwm_raw;
				s_d.out_b = !s_d.pwm_raw;
			end
		end else if (s_q.dcnt <= DB_W'(1)) begin
			s_d.out_a = s_q.pwm_raw;
			s_d.out_b = !s_q.pwm_raw;
		end

		// Read path.
		s_d.rdata = 32'h0000_0000;
		for (int c = 0; c < NUM_CHAN; c++) begin
			if (ctrl_sel[c]) begin
				s_d.rdata[7:0] = s_q.ctrl[c];
			end
			if (vlo_sel[c]) begin
				s_d.rdata[7:0] = s_q.cmp[c][7:0];
			end
			if (vhi_sel[c]) begin
				s_d.rdata[7:0] = s_q.cmp[c][15:8];
			end
		end
		case (avs_address)
			OFS_TSEL_A:      s_d.rdata[7:0] = s_q.tsel_a;
			OFS_TSEL_B:      s_d.rdata[7:0] = s_q.tsel_b;
			OFS_PWM_DB:      s_d.rdata[7:0] = s_q.db;
			OFS_PWM_PERIOD:  s_d.rdata[7:0] = s_q.period;
			OFS_PWM_DUTY:    s_d.rdata[7:0] = s_q.duty;
			OFS_IRQ_STATUS:  s_d.rdata[NUM_CHAN-1:0] = s_q.irq_st;
			OFS_IRQ_MASK:    s_d.rdata[NUM_CHAN-1:0] = s_q.irq_mask;
			OFS_PEND_STATUS: s_d.rdata[7:0] = {s_q.pend, s_q.ovf};
			default: begin
			end
		endcase
		if (!avs_read) begin
			s_d.rdata = s_q.rdata;
		end
	end

	// ----------------------------------------
	// Registers
	// ----------------------------------------
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end

	// ----------------------------------------
	// Outputs
	// ----------------------------------------
	always_comb begin
		avs_waitrequest     = (avs_read || avs_write) && !s_q.ack;
		avs_readdata        = s_q.rdata;
		timer_clear         = s_q.clr;
		timer_overflow_flag = s_q.ovf;
		adc_start           = s_q.adc;
		pwm_out_primary     = s_q.out_a;
		pwm_out_complement  = s_q.out_b;
		irq                 = |(s_q.irq_st & s_q.irq_mask);
	end

endmodule

// ---- core/ccp_pkg.sv ----
package ccp_pkg;

	// ----------------------------------------
	// Register word addresses (byte offsets)
	// ----------------------------------------
	localparam logic [7:0] OFS_CTRL_BASE   = 8'h00;
	localparam logic [7:0] OFS_VALLO_BASE  = 8'h14;
	localparam logic [7:0] OFS_VALHI_BASE  = 8'h28;
	localparam logic [7:0] OFS_TSEL_A      = 8'h3c;
	localparam logic [7:0] OFS_TSEL_B      = 8'h40;
	localparam logic [7:0] OFS_PWM_DB      = 8'h44;
	localparam logic [7:0] OFS_PWM_PERIOD  = 8'h48;
	localparam logic [7:0] OFS_PWM_DUTY    = 8'h4c;
	localparam logic [7:0] OFS_IRQ_STATUS  = 8'h50;
	localparam logic [7:0] OFS_IRQ_MASK    = 8'h54;
	localparam logic [7:0] OFS_PEND_STATUS = 8'h58;

	// ----------------------------------------
	// Field layout and codes
	// ----------------------------------------
	localparam int         MODE_LSB        = 0;
	localparam int         DUTY_LO_LSB     = 4;
	localparam int         OUT_CFG_LSB     = 6;
	localparam logic [3:0] MODE_SPECIAL    = 4'hb;
	localparam logic [1:0] MODE_PWM_TOP    = 2'h3;
	localparam logic [1:0] OUT_CFG_HALF    = 2'h2;
	localparam int         NUM_CHAN        = 5;
	localparam int         NUM_TMR         = 3;
	localparam int         ADC_CHAN        = 4;

	// ----------------------------------------
	// Reset values
	// ----------------------------------------
	localparam logic [7:0]  RST_BYTE       = 8'h00;
	localparam logic [15:0] RST_WORD       = 16'h0000;
	localparam logic [6:0]  RST_DB         = 7'h00;

endpackage

// ---- testbench/timer_model.sv ----
`timescale 1ns/1ps
// ----------------------------------------
// Three up-counting timers ticking every fourth cycle.
// ----------------------------------------
module timer_model(
	input  wire logic        sys_clk,
	input  wire logic        rstn,
	input  wire logic [2:0]  timer_clear,
	input  wire logic        load_en,
	input  wire logic [15:0] load_val,
	output logic      [2:0]  timer_tick,
	output logic      [47:0] timer_count_pair,
	output logic      [2:0]  timer_wrap
);
	logic [1:0] ph_q;
	assign timer_tick = {3{ph_q == 2'h3}};
	for (genvar t = 0; t < 3; t++) begin : g_t
		assign timer_wrap[t] = timer_count_pair[16*t +: 16] == 16'hffff;
		always_ff @(posedge sys_clk or negedge rstn) begin
			if (!rstn)
				timer_count_pair[16*t +: 16] <= 16'h0000;
			else if (timer_clear[t])
				timer_count_pair[16*t +: 16] <= 16'h0000;
			else if (load_en && t == 0)
				timer_count_pair[16*t +: 16] <= load_val;
			else if (timer_tick[t])
				timer_count_pair[16*t +: 16] <= timer_count_pair[16*t +: 16] + 16'h0001;
		end
	end
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn)
			ph_q <= 2'h0;
		else
			ph_q <= ph_q + 2'h1;
	end
endmodule

// ---- testbench/ccp_block_monitor.sv ----
`timescale 1ns/1ps
// ----------------------------------------
// Port checks.
// ----------------------------------------
module ccp_block_monitor(
	input wire logic       sys_clk,
	input wire logic       rstn,
	input wire logic       avs_read,
	input wire logic       avs_write,
	input wire logic       avs_waitrequest,
	input wire logic [2:0] timer_tick,
	input wire logic [2:0] timer_wrap,
	input wire logic [2:0] timer_clear,
	input wire logic [2:0] timer_overflow_flag,
	input wire logic       adc_enabled,
	input wire logic       adc_start,
	input wire logic       pwm_out_primary,
	input wire logic       pwm_out_complement
);
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!rstn);
	property p_clt; timer_clear[0] |-> $past(timer_tick[0]); endproperty
	property p_cl1; timer_clear[0] |=> !timer_clear[0]; endproperty
	property p_ov; $rose(timer_overflow_flag[0]) |-> $past(timer_tick[0] & timer_wrap[0]); endproperty
	property p_ovh; $fell(timer_overflow_flag[0]) |-> $past(avs_write); endproperty
	property p_ad; adc_start |-> $past(adc_enabled); endproperty
	property p_ad1; adc_start |=> !adc_start; endproperty
	property p_ex; !(pwm_out_primary && pwm_out_complement); endproperty
	property p_wt; $rose(avs_read | avs_write) |-> avs_waitrequest ##1 !avs_waitrequest; endproperty
	a_clt: assert property (p_clt) else $error("clear without tick");
	a_cl1: assert property (p_cl1) else $error("clear too long");
	a_ov: assert property (p_ov) else $error("overflow without wrap");
	a_ovh: assert property (p_ovh) else $error("overflow flag lost");
	a_ad: assert property (p_ad) else $error("conversion while off");
	a_ad1: assert property (p_ad1) else $error("conversion too long");
	a_ex: assert property (p_ex) else $error("both outputs on");
	a_wt: assert property (p_wt) else $error("wait state wrong");
	c_ad: cover property (adc_start);
	c_cl: cover property (timer_clear[0]);
	c_pw: cover property ($rose(pwm_out_complement));
endmodule
bind ccp_block ccp_block_monitor i_mon(.*);

// ---- testbench/ccp_block_test.sv ----
`timescale 1ns/1ps
// ----------------------------------------
// Register-level tests.
// ----------------------------------------
module ccp_block_test;
	import ccp_pkg::*;
	logic        sys_clk = 0, rstn = 0, avs_read = 0, avs_write = 0, load_en = 0;
	logic [7:0]  avs_address = 8'h00, q;
	logic [31:0] avs_writedata = 32'h0, avs_readdata;
	logic [15:0] load_val = 16'h0;
	logic [47:0] timer_count_pair;
	logic [2:0]  timer_tick, timer_wrap, timer_clear, timer_overflow_flag;
	logic        avs_waitrequest, adc_start, pwm_out_primary, pwm_out_complement, irq;
	int          failures = 0, num_checks = 0, n;
	wire  [4:0]  ev = {timer_overflow_flag[0], pwm_out_complement, pwm_out_primary,
		timer_clear[0], adc_start};
	always #2 sys_clk = ~sys_clk;
	ccp_block i_dut(.*, .avs_byteenable(4'hf), .adc_enabled(1'b1));
	timer_model i_tmr(.*);
	task tally_and_finish;
		$display("checks %0d failures %0d", num_checks, failures);
		if (failures == 0 && num_checks > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	task chk(input logic [15:0] seen, exp, input string what);
		num_checks++;
		if (seen !== exp) begin
			failures++;
			$display("[FAIL] %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task bus(input logic [7:0] a, input logic w, input logic [7:0] d);
		@(posedge sys_clk);
		avs_address <= a;
		avs_write <= w;
		avs_read <= !w;
		avs_writedata <= {24'h0, d};
		n = 0;
		do begin @(posedge sys_clk); n++; end while (avs_waitrequest !== 1'b0 && n < 50);
		q = avs_readdata[7:0];
		avs_read <= 1'b0;
		avs_write <= 1'b0;
		if (n >= 50) begin failures++; tally_and_finish; end
	endtask
	task rd(input logic [7:0] a, exp, input string what);
		bus(a, 1'b0, 8'h00);
		chk({8'h00, q}, {8'h00, exp}, what);
	endtask
	task waitev(input int k);
		n = 0;
		do begin @(negedge sys_clk); n++; end while (ev[k] !== 1'b1 && n < 400);
		if (n >= 400) begin failures++; tally_and_finish; end
	endtask
	initial begin
		repeat (6) @(posedge sys_clk);
		rstn <= 1'b1;
		rd(OFS_CTRL_BASE, RST_BYTE, "ctrl");
		bus(OFS_CTRL_BASE, 1'b1, 8'hdb);
		rd(OFS_CTRL_BASE, 8'hdb, "ctrl");
		bus(OFS_TSEL_A, 1'b1, 8'h3f);
		rd(OFS_TSEL_A, 8'h3f, "tsel");
		bus(OFS_TSEL_A, 1'b1, 8'h00);
		bus(OFS_CTRL_BASE, 1'b1, 8'h00);
		rd(8'hfc, 8'h00, "hole");
		@(posedge sys_clk);
		load_en <= 1'b1;
		load_val <= 16'hfffc;
		@(posedge sys_clk);
		load_en <= 1'b0;
		waitev(4);
		bus(OFS_PEND_STATUS, 1'b1, 8'h01);
		@(negedge sys_clk);
		chk(16'(timer_overflow_flag[0]), 16'h0000, "ovf");
		bus(OFS_VALLO_BASE + 8'h10, 1'b1, 8'h30);
		bus(OFS_VALHI_BASE + 8'h10, 1'b1, 8'h00);
		bus(OFS_IRQ_MASK, 1'b1, 8'h10);
		bus(OFS_CTRL_BASE + 8'h10, 1'b1, {4'h0, MODE_SPECIAL});
		for (int e = 0; e < 2; e++) begin
			waitev(0);
			chk(timer_count_pair[15:0], 16'h0030, "match");
			chk(16'(irq), 16'h0001, "irq");
			waitev(1);
			@(negedge sys_clk);
			chk(timer_count_pair[15:0], 16'h0000, "clear");
		end
		chk(16'(timer_overflow_flag[0]), 16'h0000, "ovf");
		rd(OFS_IRQ_STATUS, 8'h10, "status");
		bus(OFS_IRQ_MASK, 1'b1, 8'h00);
		@(negedge sys_clk);
		chk(16'(irq), 16'h0000, "mask");
		bus(OFS_CTRL_BASE + 8'h10, 1'b1, 8'h00);
		bus(OFS_IRQ_STATUS, 1'b1, 8'h10);
		rd(OFS_IRQ_STATUS, 8'h00, "w1c");
		bus(OFS_PWM_PERIOD, 1'b1, 8'h01);
		bus(OFS_PWM_DUTY, 1'b1, 8'h01);
		bus(OFS_PWM_DB, 1'b1, 8'h00);
		bus(OFS_CTRL_BASE, 1'b1, {OUT_CFG_HALF, 2'h0, MODE_PWM_TOP, 2'h0});
		waitev(2);
		waitev(3);
		chk(16'(pwm_out_primary), 16'h0000, "pair");
		bus(OFS_PWM_DB, 1'b1, 8'h7f);
		repeat (40) @(negedge sys_clk);
		n = 0;
		repeat (64) begin
			@(negedge sys_clk);
			if (pwm_out_primary !== 1'b0 || pwm_out_complement !== 1'b0)
				n++;
		end
		chk(16'(n), 16'h0000, "dead");
		tally_and_finish;
	end
endmodule
